// File: hdl/lcdft_core.sv
// Purpose: Command decoder, configuration state and frame timing for a 4 x 44 LCD driver
// Assumes: Bytes arrive already deserialised with their register select field
// Notes:   Commands and data are ignored until the initialize strobe has been seen
// Behaviour
// - Low-rate external clock: frame = input / 48
// - High-rate clock: frame = input / (48 * q)
// - Divider code maps to q, 80 down to 16
// - Opcode 001 loads five-bit divider code
// - Opcode 0000 01 loads bias selection
// - Opcode 10 loads six-bit column pointer
// - Pointer increments after each RAM write
// - Pointer above 43 discarded, writes suppressed
// - RAM written only when select field 01
// - After reset: display off, clock pin released
// - Reset and init restore all default values
// - Reset pin leaves RAM contents unchanged
// - Prescaler only for internal or high-rate
// - Clock pin carries oscillator divided by q
// - Opcode 0001 1 sets rate, output, source
// - Display disabled holds display_on_o and frame_tick_o low
// - RAM is 44 columns of four bits
`timescale 1ns/1ps
module lcdft_core
  import lcdft_pkg::*;
#(
  parameter int unsigned OSC_DIV = OSC_TICK_CYCLES
) (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       init_i,
  input  wire logic       cmd_valid_i,
  input  wire logic [1:0] register_select_field_i,
  input  wire logic [7:0] cmd_byte_i,
  input  wire logic       display_enable_i,
  input  wire logic       oscillator_clock_pin_i,
  output logic            oscillator_clock_pin_o,
  output logic            oscillator_clock_pin_oe_o,
  input  wire logic [5:0] ram_rd_addr_i,
  output logic      [3:0] ram_rd_data_o,
  output logic            display_on_o,
  output logic      [1:0] bias_select_o,
  output logic      [4:0] frame_divider_code_o,
  output logic      [5:0] ram_column_pointer_o,
  output logic            pointer_valid_o,
  output logic            frame_tick_o,
  output logic            initialized_o
);

  if (OSC_DIV < 2 || OSC_DIV > 65535) begin : g_bad_div
    $error("lcdft_core: OSC_DIV must be 2 to 65535");
  end

  // Configuration state
  logic [4:0]  fd;
  logic [1:0]  bias;
  logic        ext_clock_rate_select;
  logic        clock_out_drive_enable;
  logic        clock_source_select;
  logic [5:0]  ptr;
  logic        ptr_ok;
  logic        inited;
  logic [4:0]  next_fd;
  logic [1:0]  next_bias;
  logic        next_rate;
  logic        next_coe;
  logic        next_src;
  logic [5:0]  next_ptr;
  logic        next_ptr_ok;
  logic        next_inited;
  logic        ram_we;
  logic [3:0]  ram_wdata;

  // Command decode
  logic        is_cmd;
  logic        is_data;
  logic        op_fd;
  logic        op_bias;
  logic        op_osc;
  logic        op_ptr;
  assign is_cmd  = cmd_valid_i && inited && (register_select_field_i == RS_COMMAND);
  assign is_data = cmd_valid_i && inited && (register_select_field_i == RS_RAM_DATA);
  assign op_fd   = is_cmd && (cmd_byte_i[7:5] == OP_FRAME_FREQ);
  assign op_bias = is_cmd && (cmd_byte_i[7:2] == OP_BIAS);
  assign op_osc  = is_cmd && (cmd_byte_i[7:3] == OP_OSC_CTRL);
  assign op_ptr  = is_cmd && (cmd_byte_i[7:6] == OP_LOAD_PTR);

  always_comb begin
    next_fd     = fd;
    next_bias   = bias;
    next_rate   = ext_clock_rate_select;
    next_coe    = clock_out_drive_enable;
    next_src    = clock_source_select;
    next_ptr    = ptr;
    next_ptr_ok = ptr_ok;
    next_inited = inited;
    ram_we      = 1'b0;
    ram_wdata   = cmd_byte_i[3:0];
    if (init_i) begin
      next_fd     = FD_DEFAULT;
      next_bias   = BIAS_DEFAULT;
      next_rate   = 1'b0;
      next_coe    = 1'b0;
      next_src    = 1'b0;
      next_ptr    = PTR_DEFAULT;
      next_ptr_ok = 1'b1;
      next_inited = 1'b1;
    end else begin
      if (op_fd && cmd_byte_i[4:0] <= FD_LAST_VALID) begin
        next_fd = cmd_byte_i[4:0];
      end
      if (op_bias) begin
        next_bias = cmd_byte_i[1:0];
      end
      if (op_osc) begin
        next_rate = cmd_byte_i[OSC_RATE_BIT];
        next_coe  = cmd_byte_i[OSC_COE_BIT];
        next_src  = cmd_byte_i[OSC_SRC_BIT];
      end
      if (op_ptr) begin
        if (cmd_byte_i[5:0] <= PTR_LAST_VALID) begin
          next_ptr    = cmd_byte_i[5:0];
          next_ptr_ok = 1'b1;
        end else begin
          next_ptr_ok = 1'b0;
        end
      end
      if (is_data && ptr_ok) begin
        ram_we = 1'b1;
        if (ptr == PTR_LAST_VALID) begin
          next_ptr = PTR_DEFAULT;
        end else begin
          next_ptr = ptr + 6'h01;
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fd                     <= FD_DEFAULT;
      bias                   <= BIAS_DEFAULT;
      ext_clock_rate_select  <= 1'b0;
      clock_out_drive_enable <= 1'b0;
      clock_source_select    <= 1'b0;
      ptr                    <= PTR_DEFAULT;
      ptr_ok                 <= 1'b1;
      inited                 <= 1'b0;
    end else begin
      fd                     <= next_fd;
      bias                   <= next_bias;
      ext_clock_rate_select  <= next_rate;
      clock_out_drive_enable <= next_coe;
      clock_source_select    <= next_src;
      ptr                    <= next_ptr;
      ptr_ok                 <= next_ptr_ok;
      inited                 <= next_inited;
    end
  end

  // Clock pin input: three flops, level taken when second and third agree
  logic       pin_s1;
  logic       pin_s2;
  logic       pin_s3;
  logic       pin_level;
  logic       next_pin_level;
  logic       ext_tick;
  assign next_pin_level = (pin_s2 == pin_s3) ? pin_s3 : pin_level;
  assign ext_tick       = next_pin_level && !pin_level;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_s1    <= 1'b0;
      pin_s2    <= 1'b0;
      pin_s3    <= 1'b0;
      pin_level <= 1'b0;
    end else begin
      pin_s1    <= oscillator_clock_pin_i;
      pin_s2    <= pin_s1;
      pin_s3    <= pin_s2;
      pin_level <= next_pin_level;
    end
  end

  // Internal oscillator, always running
  logic [15:0] osc_cnt;
  logic [15:0] next_osc_cnt;
  logic        osc_tick;
  assign osc_tick     = (osc_cnt == 16'(OSC_DIV - 1));
  assign next_osc_cnt = osc_tick ? 16'h0000 : osc_cnt + 16'h0001;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      osc_cnt <= 16'h0000;
    end else begin
      osc_cnt <= next_osc_cnt;
    end
  end

  // Frame timing
  lcdft_timing_if tif ();
  assign tif.src_tick = clock_source_select ? ext_tick : osc_tick;
  assign tif.bypass   = clock_source_select && !ext_clock_rate_select;
  assign tif.q        = lcdft_q_of(fd);

  lcdft_frame_timer u_timer (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .tif     (tif.timer)
  );

  lcdft_ram u_ram (
    .clk_i     (clk_i),
    .wr_en_i   (ram_we),
    .wr_addr_i (ptr),
    .wr_data_i (ram_wdata),
    .rd_addr_i (ram_rd_addr_i),
    .rd_data_o (ram_rd_data_o)
  );

  // Registered outputs
  logic       next_pin_oe;
  logic       next_disp_on;
  assign next_pin_oe  = inited && !clock_source_select && clock_out_drive_enable;
  assign next_disp_on = inited && display_enable_i;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      oscillator_clock_pin_o    <= 1'b0;
      oscillator_clock_pin_oe_o <= 1'b0;
      display_on_o              <= 1'b0;
      bias_select_o             <= BIAS_DEFAULT;
      frame_divider_code_o      <= FD_DEFAULT;
      ram_column_pointer_o      <= PTR_DEFAULT;
      pointer_valid_o           <= 1'b1;
      frame_tick_o              <= 1'b0;
      initialized_o             <= 1'b0;
    end else begin
      oscillator_clock_pin_o    <= next_pin_oe && tif.inter_clk;
      oscillator_clock_pin_oe_o <= next_pin_oe;
      display_on_o              <= next_disp_on;
      bias_select_o             <= bias;
      frame_divider_code_o      <= fd;
      ram_column_pointer_o      <= ptr;
      pointer_valid_o           <= ptr_ok;
      frame_tick_o              <= tif.frame_tick && next_disp_on;
      initialized_o             <= inited;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_data_write;
    is_data && ptr_ok && !init_i;
  endsequence

  sequence s_bad_ptr;
    op_ptr && !init_i && cmd_byte_i[5:0] > PTR_LAST_VALID;
  endsequence

  a_fd_load: assert property (
    (op_fd && !init_i && cmd_byte_i[4:0] <= FD_LAST_VALID) |=> fd == $past(cmd_byte_i[4:0]))
    else $error("divider code not loaded");

  a_fd_reserved: assert property (
    (op_fd && !init_i && cmd_byte_i[4:0] > FD_LAST_VALID) |=> $stable(fd))
    else $error("reserved divider code changed state");

  a_bias_load: assert property (
    (op_bias && !init_i) |=> ##1 bias_select_o == $past(cmd_byte_i[1:0], 2))
    else $error("bias not loaded");

  a_ptr_load: assert property (
    (op_ptr && !init_i && cmd_byte_i[5:0] <= PTR_LAST_VALID) |=> (ptr == $past(cmd_byte_i[5:0]) && ptr_ok))
    else $error("pointer not loaded");

  a_ptr_discard: assert property (
    s_bad_ptr ##1 (!(op_ptr && cmd_byte_i[5:0] <= PTR_LAST_VALID) && !init_i) |=> !ptr_ok && !$past(ram_we))
    else $error("bad pointer not discarded");

  a_ptr_incr: assert property (
    s_data_write |=> ptr == (($past(ptr) == PTR_LAST_VALID) ? PTR_DEFAULT : $past(ptr) + 6'h01))
    else $error("pointer did not advance");

  a_init_defaults: assert property (
    init_i |=> (fd == FD_DEFAULT && ptr == PTR_DEFAULT && bias == BIAS_DEFAULT
                && !clock_source_select && !clock_out_drive_enable && !ext_clock_rate_select))
    else $error("init did not restore defaults");

  a_pin_released: assert property (
    (!inited || clock_source_select || !clock_out_drive_enable) |=> !oscillator_clock_pin_oe_o)
    else $error("clock pin driven when it must be released");

  a_display_off: assert property (
    !display_enable_i |=> !display_on_o ##0 !frame_tick_o)
    else $error("display on while disabled");

  a_ram_gate: assert property (
    ram_we |-> (register_select_field_i == RS_RAM_DATA && ptr_ok))
    else $error("RAM written outside data byte");

endmodule

// File: hdl/lcdft_frame_timer.sv
// Purpose: Prescaler by q then frame counter by 48
// Assumes: src_tick marks one period of the selected oscillator
// Notes:   With bypass the prescaler is skipped
`timescale 1ns/1ps
module lcdft_frame_timer
  import lcdft_pkg::*;
(
  input  wire logic     clk_i,
  input  wire logic     rst_n_i,
  lcdft_timing_if.timer tif
);

  logic [6:0] presc;
  logic [5:0] frame_cnt;
  logic       inter_clk;
  logic       inter_tick;
  logic       frame_tick;
  logic [6:0] next_presc;
  logic [5:0] next_frame_cnt;
  logic       next_inter_clk;
  logic       next_inter_tick;
  logic       next_frame_tick;
  logic       stage_tick;

  always_comb begin
    next_presc      = presc;
    next_frame_cnt  = frame_cnt;
    next_inter_tick = 1'b0;
    next_frame_tick = 1'b0;
    stage_tick      = 1'b0;
    if (tif.bypass) begin
      next_presc = 7'h00;
      stage_tick = tif.src_tick;
    end else if (tif.src_tick) begin
      if (presc >= tif.q - 7'h01) begin
        next_presc      = 7'h00;
        stage_tick      = 1'b1;
        next_inter_tick = 1'b1;
      end else begin
        next_presc = presc + 7'h01;
      end
    end
    if (stage_tick) begin
      if (32'(frame_cnt) == FRAME_DIV - 1) begin
        next_frame_cnt  = 6'h00;
        next_frame_tick = 1'b1;
      end else begin
        next_frame_cnt = frame_cnt + 6'h01;
      end
    end
    next_inter_clk = (next_presc < {1'b0, tif.q[6:1]});
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      presc      <= 7'h00;
      frame_cnt  <= 6'h00;
      inter_clk  <= 1'b0;
      inter_tick <= 1'b0;
      frame_tick <= 1'b0;
    end else begin
      presc      <= next_presc;
      frame_cnt  <= next_frame_cnt;
      inter_clk  <= next_inter_clk;
      inter_tick <= next_inter_tick;
      frame_tick <= next_frame_tick;
    end
  end

  assign tif.inter_clk   = inter_clk;
  assign tif.inter_tick  = inter_tick;
  assign tif.frame_tick  = frame_tick;
  assign tif.frame_phase = frame_cnt;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_presc_wrap: assert property (
    (!tif.bypass && tif.src_tick && presc == tif.q - 7'h01) |=> (inter_tick && presc == 7'h00))
    else $error("prescaler did not wrap at q");

  a_frame_wrap: assert property (
    (tif.src_tick && tif.bypass && 32'(frame_cnt) == FRAME_DIV - 1) |=> (frame_tick && frame_cnt == 6'h00))
    else $error("frame counter did not wrap at 48");

endmodule

// File: hdl/lcdft_pkg.sv
// Purpose: Shared constants and the divide-factor table for the LCD frame timing and command decoder
// Assumes: 125 MHz system clock; internal oscillator modelled as a tick at its nominal rate
// Notes:   Command opcodes, reset values and timing counts live here only
package lcdft_pkg;

  localparam int unsigned CLK_FREQ_HZ     = 125000000;
  localparam int unsigned OSC_FREQ_HZ     = 230000;
  localparam int unsigned OSC_TICK_CYCLES = CLK_FREQ_HZ / OSC_FREQ_HZ;

  localparam int unsigned FRAME_DIV       = 48;
  localparam int unsigned RAM_COLS        = 44;
  localparam int unsigned RAM_BITS        = 4;

  // Command byte decode
  localparam logic [2:0] OP_FRAME_FREQ    = 3'h1;
  localparam logic [5:0] OP_BIAS          = 6'h01;
  localparam logic [4:0] OP_OSC_CTRL      = 5'h03;
  localparam logic [1:0] OP_LOAD_PTR      = 2'h2;

  // Register select field values
  localparam logic [1:0] RS_COMMAND       = 2'h0;
  localparam logic [1:0] RS_RAM_DATA      = 2'h1;

  // Oscillator-control field positions
  localparam int unsigned OSC_RATE_BIT    = 2;
  localparam int unsigned OSC_COE_BIT     = 1;
  localparam int unsigned OSC_SRC_BIT     = 0;

  // Reset values and last valid codes
  localparam logic [4:0] FD_DEFAULT       = 5'h0e;
  localparam logic [4:0] FD_LAST_VALID    = 5'h16;
  localparam logic [5:0] PTR_DEFAULT      = 6'h00;
  localparam logic [5:0] PTR_LAST_VALID   = 6'h2b;
  localparam logic [1:0] BIAS_DEFAULT     = 2'h0;
  localparam logic [6:0] Q_DEFAULT        = 7'h18;

  function automatic logic [6:0] lcdft_q_of(input logic [4:0] code);
    logic [6:0] q;
    q = Q_DEFAULT;
    case (code)
      5'h00:   q = 7'h50;
      5'h01:   q = 7'h44;
      5'h02:   q = 7'h3c;
      5'h03:   q = 7'h35;
      5'h04:   q = 7'h30;
      5'h05:   q = 7'h2c;
      5'h06:   q = 7'h28;
      5'h07:   q = 7'h25;
      5'h08:   q = 7'h22;
      5'h09:   q = 7'h20;
      5'h0a:   q = 7'h1e;
      5'h0b:   q = 7'h1c;
      5'h0c:   q = 7'h1b;
      5'h0d:   q = 7'h19;
      5'h0e:   q = 7'h18;
      5'h0f:   q = 7'h17;
      5'h10:   q = 7'h16;
      5'h11:   q = 7'h15;
      5'h12:   q = 7'h14;
      5'h13:   q = 7'h13;
      5'h14:   q = 7'h12;
      5'h15:   q = 7'h11;
      5'h16:   q = 7'h10;
      default: q = Q_DEFAULT;
    endcase
    return q;
  endfunction

endpackage

// File: hdl/lcdft_ram.sv
// Purpose: Display RAM, columns of nibbles, registered read port
// Assumes: Write address range-checked by the caller; read addresses checked here, zero beyond COLS
// Notes:   No reset; contents survive the reset pin
`timescale 1ns/1ps
module lcdft_ram
  import lcdft_pkg::*;
#(
  parameter int unsigned COLS = RAM_COLS,
  parameter int unsigned BITS = RAM_BITS
) (
  input  wire logic            clk_i,
  input  wire logic            wr_en_i,
  input  wire logic [5:0]      wr_addr_i,
  input  wire logic [BITS-1:0] wr_data_i,
  input  wire logic [5:0]      rd_addr_i,
  output logic      [BITS-1:0] rd_data_o
);

  if (COLS < 1 || COLS > 64) begin : g_bad_cols
    $error("lcdft_ram: COLS must be 1 to 64");
  end

  logic [BITS-1:0] mem [COLS];

  always_ff @(posedge clk_i) begin
    if (wr_en_i && (32'(wr_addr_i) < COLS)) begin
      mem[wr_addr_i] <= wr_data_i;
    end
    if (32'(rd_addr_i) < COLS) begin
      rd_data_o <= mem[rd_addr_i];
    end else begin
      rd_data_o <= '0;
    end
  end

endmodule

// File: hdl/lcdft_timing_if.sv
// Purpose: Carries source ticks and divider settings into the frame timer and its outputs back
// Assumes: One clock domain
// Notes:   Ticks are one-cycle pulses
`timescale 1ns/1ps
interface lcdft_timing_if;
  logic       src_tick;
  logic       bypass;
  logic [6:0] q;
  logic       inter_clk;
  logic       inter_tick;
  logic       frame_tick;
  logic [5:0] frame_phase;

  modport ctrl  (output src_tick, output bypass, output q,
                 input inter_clk, input inter_tick, input frame_tick, input frame_phase);
  modport timer (input src_tick, input bypass, input q,
                 output inter_clk, output inter_tick, output frame_tick, output frame_phase);
endinterface

// File: tb/lcdft_core_tb.sv
// Purpose: Self-checking bench for the LCD frame timing and command decoder
// Assumes: OSC_DIV shortened to 4 clock cycles
// Notes:   Frame and pin periods are measured in clock cycles between pulses
`timescale 1ns/1ps
module lcdft_core_tb;
  import lcdft_pkg::*;
  localparam int unsigned DIV = 4;

  logic       clk;
  logic       rst_n;
  logic       disp_en;
  logic [5:0] rd_addr;
  logic       init;
  logic       cmd_valid;
  logic [1:0] rs;
  logic [7:0] cmd_byte;
  logic       ext_clk;
  logic       pin_o;
  logic       pin_oe;
  logic       pin_w;
  logic [3:0] rd_data;
  logic       disp_on;
  logic [1:0] bias;
  logic [4:0] code;
  logic [5:0] ptr;
  logic       ptr_ok;
  logic       frame_tick;
  logic       inited;
  int         n_errors;
  int         tests_run;

  assign pin_w = pin_oe ? pin_o : ext_clk;

  lcdft_host_model lcdft_host_model_i (
    .clk_i       (clk),
    .init_o      (init),
    .cmd_valid_o (cmd_valid),
    .rs_o        (rs),
    .byte_o      (cmd_byte),
    .ext_clk_o   (ext_clk)
  );

  lcdft_core #(.OSC_DIV(DIV)) lcdft_core_i (
    .clk_i                     (clk),
    .rst_n_i                   (rst_n),
    .init_i                    (init),
    .cmd_valid_i               (cmd_valid),
    .register_select_field_i   (rs),
    .cmd_byte_i                (cmd_byte),
    .display_enable_i          (disp_en),
    .oscillator_clock_pin_i    (pin_w),
    .oscillator_clock_pin_o    (pin_o),
    .oscillator_clock_pin_oe_o (pin_oe),
    .ram_rd_addr_i             (rd_addr),
    .ram_rd_data_o             (rd_data),
    .display_on_o              (disp_on),
    .bias_select_o             (bias),
    .frame_divider_code_o      (code),
    .ram_column_pointer_o      (ptr),
    .pointer_valid_o           (ptr_ok),
    .frame_tick_o              (frame_tick),
    .initialized_o             (inited)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    if (n_errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic do_reset();
    @(negedge clk);
    rst_n = 1'b0;
    wt(8);
    rst_n = 1'b1;
  endtask

  task automatic cmd(input logic [1:0] r, input logic [7:0] b);
    lcdft_host_model_i.send(r, b);
    wt(3);
  endtask

  task automatic rd(input logic [5:0] a, input logic [3:0] exp);
    rd_addr = a;
    wt(2);
    check(16'(rd_data), 16'(exp));
  endtask

  // Cycles between two events: frame ticks, or rising edges of the clock pin
  task automatic period(input bit pin, input int exp);
    int   n;
    bit   seen;
    logic prev;
    n    = 0;
    seen = 1'b0;
    prev = 1'b1;
    while (n < 20000) begin
      @(negedge clk);
      if (pin ? (pin_o && !prev) : frame_tick) begin
        if (seen)
          break;
        seen = 1'b1;
        n    = 0;
      end
      prev = pin_o;
      n++;
    end
    check(16'(n), 16'(exp));
  endtask

  task automatic t_reset();
    do_reset();
    cmd(2'h0, 8'h06);
    check(16'(code), 16'h0e);
    check(16'(ptr), 16'h00);
    check(16'(bias), 16'h0);
    check(16'(pin_oe), 16'h0);
    check(16'(inited), 16'h0);
    lcdft_host_model_i.init_dev();
    wt(3);
    check(16'(inited), 16'h1);
    check(16'(disp_on), 16'h0);
  endtask

  task automatic t_bias();
    for (int i = 3; i >= 0; i--) begin
      cmd(2'h0, 8'h04 | 8'(i));
      check(16'(bias), 16'(i));
    end
  endtask

  task automatic t_div();
    cmd(2'h0, 8'h36);
    check(16'(code), 16'h16);
    cmd(2'h0, 8'h37);
    check(16'(code), 16'h16);
    cmd(2'h0, 8'h20);
    check(16'(code), 16'h00);
  endtask

  task automatic t_ram();
    cmd(2'h0, 8'hab);
    check(16'(ptr), 16'h2b);
    lcdft_host_model_i.send(2'h1, 8'hf5);
    cmd(2'h1, 8'h3a);
    check(16'(ptr), 16'h01);
    cmd(2'h2, 8'h0c);
    check(16'(ptr), 16'h01);
    rd(6'h2b, 4'h5);
    rd(6'h00, 4'ha);
    cmd(2'h0, 8'hac);
    check(16'(ptr_ok), 16'h0);
    check(16'(ptr), 16'h01);
    cmd(2'h1, 8'h07);
    check(16'(ptr), 16'h01);
    cmd(2'h0, 8'h85);
    check(16'(ptr_ok), 16'h1);
    check(16'(ptr), 16'h05);
  endtask

  task automatic t_keep();
    do_reset();
    lcdft_host_model_i.init_dev();
    wt(3);
    check(16'(ptr), 16'h00);
    check(16'(code), 16'h0e);
    rd(6'h2b, 4'h5);
    rd(6'h00, 4'ha);
  endtask

  task automatic t_frame();
    int ticks;
    ticks   = 0;
    disp_en = 1'b1;
    period(1'b0, DIV * 24 * 48);
    check(16'(disp_on), 16'h1);
    cmd(2'h0, 8'h36);
    period(1'b0, DIV * 16 * 48);
    cmd(2'h0, 8'h1a);
    check(16'(pin_oe), 16'h1);
    period(1'b1, DIV * 16);
    lcdft_host_model_i.ext_half = 4;
    cmd(2'h0, 8'h19);
    check(16'(pin_oe), 16'h0);
    period(1'b0, 8 * 48);
    cmd(2'h0, 8'h1d);
    period(1'b0, 8 * 16 * 48);
    disp_en = 1'b0;
    wt(3);
    check(16'(disp_on), 16'h0);
    // No frame pulse may leave the block while the display is off
    repeat (8 * 16 * 48 + 8) begin
      @(negedge clk);
      if (frame_tick !== 1'b0)
        ticks++;
    end
    check(16'(ticks), 16'h0);
  endtask

  initial begin
    n_errors  = 0;
    tests_run = 0;
    rst_n     = 1'b0;
    disp_en   = 1'b0;
    rd_addr   = 6'h00;
    t_reset();
    t_bias();
    t_div();
    t_ram();
    t_keep();
    t_frame();
    stop_test();
  end

  initial begin
    #600000;
    n_errors++;
    stop_test();
  end
endmodule

// File: tb/lcdft_host_model.sv
// Purpose: Host side model: initialize strobe, command and data bytes, external clock on the pin
// Assumes: Inputs of the block are changed at the falling edge of clk_i
// Notes:   Released byte lines show the inverse of the last byte with an ignored select code
`timescale 1ns/1ps
module lcdft_host_model (
  input  wire logic       clk_i,
  output logic            init_o,
  output logic            cmd_valid_o,
  output logic      [1:0] rs_o,
  output logic      [7:0] byte_o,
  output logic            ext_clk_o
);
  int unsigned ext_half;

  initial begin
    init_o      = 1'b0;
    cmd_valid_o = 1'b0;
    rs_o        = 2'h3;
    byte_o      = 8'h00;
    ext_clk_o   = 1'b0;
    ext_half    = 0;
  end

  // Initialize strobe, sent after every power-up or reset release
  task automatic init_dev();
    @(negedge clk_i);
    init_o = 1'b1;
    @(negedge clk_i);
    init_o = 1'b0;
  endtask

  // One byte for one cycle, then the lines are released
  task automatic send(input logic [1:0] rs, input logic [7:0] b);
    @(negedge clk_i);
    cmd_valid_o = 1'b1;
    rs_o        = rs;
    byte_o      = b;
    @(negedge clk_i);
    cmd_valid_o = 1'b0;
    rs_o        = 2'h3;
    byte_o      = ~b;
  endtask

  // External clock, period 2*ext_half cycles; stands still while ext_half is 0
  always begin
    @(negedge clk_i);
    if (ext_half != 0) begin
      repeat (ext_half - 1) @(negedge clk_i);
      ext_clk_o = ~ext_clk_o;
    end
  end
endmodule
